// ===== common/eth_pkg.sv
// Package for the external-temperature and self-heating model block.
// Assumes an APB slave with 32-bit data and four channels.
package eth_pkg;
	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int NCH         = 4;
	localparam int CH_STRIDE   = 32;            // byte stride per channel
	// ------------------------------------------------------------
	// Register offsets within a channel window
	// ------------------------------------------------------------
	localparam logic [4:0] OFF_GAIN    = 5'h00; // diode_gain_inverse
	localparam logic [4:0] OFF_OFFSET  = 5'h04; // temperature offset
	localparam logic [4:0] OFF_THETA   = 5'h08; // inductor_thermal_resistance
	localparam logic [4:0] OFF_TAU     = 5'h0c; // thermal_tau_inverse
	localparam logic [4:0] OFF_TC      = 5'h10; // sense_gain_tempco
	localparam logic [4:0] OFF_RISE    = 5'h14; // inductor_temp_rise
	localparam logic [4:0] OFF_TEMP    = 5'h18; // calibrated temperature
	localparam logic [4:0] OFF_CORR    = 5'h1c; // gain correction factor
	// ------------------------------------------------------------
	// Fixed-point formats
	// ------------------------------------------------------------
	// Temperatures signed Q8.8 deg C (kelvin input unsigned Q10.6)
	localparam int GAIN_FRAC   = 14;
	localparam logic [15:0] GAIN_RST   = 16'h4000; // unity gain
	localparam logic [15:0] OFFSET_RST = 16'h0000;
	localparam logic [15:0] THETA_RST  = 16'h0000; // Q8.8 C/W
	localparam logic [15:0] TAU_RST    = 16'h0000; // Q1.15 signed
	localparam logic [15:0] TC_RST     = 16'h0000; // ppm/C signed
	localparam int TAU_FRAC    = 15;
	localparam logic [31:0] KELVIN_OFS = 32'h0001_1126; // 273.15 in Q8.8
	localparam logic signed [31:0] RISE_MAX   = 32'sh0000_3200; // 50 C
	localparam logic signed [31:0] T_REF      = 32'sh0000_1900; // 25 C
	// Correction factor Q2.14 unsigned, clamp 0.25..4.0
	localparam int CORR_FRAC   = 14;
	localparam logic signed [47:0] CORR_MIN = 48'sh0000_0000_1000;
	localparam logic signed [47:0] CORR_MAX = 48'sh0000_0001_0000;
	localparam logic signed [47:0] PPM_DIV  = 48'sd1000000;
	// Power Q8.8 W = current Q8.8 A * sense voltage Q0.16 V
	localparam int P_SHIFT     = 16;
	// ------------------------------------------------------------
	// Model step: four sense conversion times per loop
	// ------------------------------------------------------------
	localparam int STEP_CONV   = 4;
	localparam int CONV_TIME_US = 16500; // sense_conversion_time
	localparam int CLK_MHZ     = 100;
	localparam int STEP_CYC    = STEP_CONV * CONV_TIME_US * CLK_MHZ;
	typedef enum logic [1:0] {ETH_IDLE, ETH_CALC, ETH_STORE} eth_state_e;
endpackage

// ===== dv/eth_model_monitor.sv
// Port checker for the temperature and self-heating block.
// Assumes a bind from the bench top file; one clock domain, pclk.
`timescale 1ns/1ps
module eth_model_monitor (
	// Clock and reset
	input wire logic                        pclk,
	input wire logic                        presetn,
	// APB slave side
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pwrite,
	input wire logic [7:0]                  paddr,
	input wire logic [31:0]                 prdata,
	input wire logic                        pready,
	input wire logic                        pslverr,
	// Measurement and results
	input wire logic                        meas_done,
	input wire logic [eth_pkg::NCH*16-1:0] temp_out,
	input wire logic [eth_pkg::NCH*16-1:0] gain_corr
);
	// ------------------------------------------------
	// Decode of the access in flight
	// ------------------------------------------------
	wire acc_w = psel && penable && !pready;
	wire bad_w = paddr[7] || (paddr[1:0] != 2'b00);
	wire ro_w  = pwrite && (paddr[4:0] >= eth_pkg::OFF_RISE);
	wire lo_w  = (gain_corr[15:0] >= 16'h1000)
		&& (gain_corr[31:16] >= 16'h1000)
		&& (gain_corr[47:32] >= 16'h1000)
		&& (gain_corr[63:48] >= 16'h1000);
	// ------------------------------------------------
	// Properties
	// ------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_one_wait: assert property (acc_w |=> pready)
		else $error("pready not one cycle after access");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_bad_addr: assert property (acc_w && bad_w |=> pready && pslverr)
		else $error("unmapped access without error");
	chk_ro_write: assert property (acc_w && ro_w |=> pslverr)
		else $error("read-only write without error");
	chk_good_okay: assert property (acc_w && !bad_w && !ro_w |=> !pslverr)
		else $error("error on a legal access");
	chk_err_zero: assert property (pready && pslverr && !pwrite |-> !prdata)
		else $error("refused read returned data");
	chk_temp_hold: assert property (
		$past(presetn, 2) && !$past(meas_done, 2) |-> $stable(temp_out))
		else $error("temperature moved without a loop");
	chk_corr_hold: assert property (
		$past(presetn, 2) && !$past(meas_done, 2) |-> $stable(gain_corr))
		else $error("correction moved without a loop");
	chk_corr_range: assert property ($past(presetn) |-> lo_w)
		else $error("correction below lower clamp");
endmodule

// ===== dv/eth_model_tb_top.sv
// Self-checking bench for the temperature and self-heating block.
// Assumes eth_pkg and eth_model are compiled before this file.
`timescale 1ns/1ps
module eth_model_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, meas_done, er;
	logic [7:0]  paddr, base;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb, sensor_valid;
	logic        pready, pslverr;
	logic [15:0] die_temp;
	logic [63:0] diode_kelvin, sense_current, sense_plus_voltage;
	logic [63:0] sense_minus_voltage, temp_out, gain_corr;
	int num_errors, checks_done, seed, ch, kv, ofs, ex, rise;
	int th[11] = '{0, 4096, 28672, 4096, 4096, -4096, 4096, 0, 0, 0, 4096};
	int tu[11] = '{32767, 32767, 32767, 16384, 16384, 32767, 0, 0, 0, 0,
		32767};
	int tc[11] = '{0, 0, 0, 0, 0, 0, 0, 10000, -32768, 32767, 10000};
	int dt[11] = '{0, 0, 0, 0, 0, 0, 0, 12800, 32000, 32000, 10752};
	eth_model dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .meas_done(meas_done),
		.sensor_valid(sensor_valid), .diode_kelvin(diode_kelvin),
		.die_temp(die_temp), .sense_current(sense_current),
		.sense_plus_voltage(sense_plus_voltage),
		.sense_minus_voltage(sense_minus_voltage),
		.temp_out(temp_out), .gain_corr(gain_corr));
	// Clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Compare and count
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One APB transfer, waits for pready
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Look mid-cycle, then complete at the edge that sees pready
		do begin
			@(negedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		@(posedge pclk);
		if (n >= 20) num_errors++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// One temperature loop end
	task automatic meas();
		@(posedge pclk);
		meas_done <= 1'b1;
		@(posedge pclk);
		meas_done <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask
	// Reference model of the rise, all Q8.8 except tau Q1.15
	function automatic int step(int r, int t, int u, int p);
		int s;
		s = t * p / 256;
		if (t <= 0 || u <= 0) return 0;
		r = (u >= 32767) ? s : r + u * (s - r) / 32768;
		return (r < 0) ? 0 : (r > 12800) ? 12800 : r;
	endfunction
	// Reference model of the correction, q is T+rise-25 in Q8.8
	function automatic int corr(int c, int q);
		int v;
		v = 16384 + c * q / 15625;
		return (v < 4096) ? 4096 : (v > 65535) ? 65535 : v;
	endfunction
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog
	initial begin
		#200000;
		num_errors++;
		summarize();
	end
	// Main sequence
	initial begin
		seed = 32'ha8fb8b4f;
		{psel, penable, pwrite, meas_done, presetn} = '0;
		{paddr, pwdata, die_temp} = '0;
		pstrb = 4'hf;
		sensor_valid = 4'hf;
		ch = $random(seed) & 3;
		base = 8'(ch * 32);
		kv = 16'h4400 + ($random(seed) & 16'h0ffe);
		ofs = $random(seed) & 16'h0fff;
		diode_kelvin = {4{kv[15:0]}};
		sense_current = {4{16'h0200}};
		sense_plus_voltage = {4{16'h5000}};
		sense_minus_voltage = {4{16'h1000}};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, base + 8'(i * 4), 32'h0);
			chk("reset reg", rd, (i == 0 || i == 7) ? 32'h4000 : 32'h0);
		end
		for (int i = 0; i < 3; i++) begin
			apb(i == 2, (i == 0) ? 8'h80 : base + 8'(i * 18 - 16), 32'h5);
			chk("refused", {er, rd}, {1'b1, 32'h0});
		end
		$display("test registers done");
		apb(1'b1, base + eth_pkg::OFF_GAIN, 32'h4800);
		apb(1'b1, base + eth_pkg::OFF_OFFSET, ofs);
		meas();
		ex = kv * 4 * 18432 / 16384 - int'(eth_pkg::KELVIN_OFS) + ofs;
		apb(1'b0, base + eth_pkg::OFF_TEMP, 32'h0);
		chk("temp reg", rd, {16'h0, ex[15:0]});
		chk("temp out", temp_out[ch*16 +: 16], ex[15:0]);
		sensor_valid[ch] <= 1'b0;
		die_temp <= 16'($random(seed));
		meas();
		chk("die temp", temp_out[ch*16 +: 16], die_temp);
		$display("test temperature done");
		rise = 0;
		for (int i = 0; i < 11; i++) begin
			apb(1'b1, base + eth_pkg::OFF_THETA, th[i]);
			apb(1'b1, base + eth_pkg::OFF_TAU, tu[i]);
			apb(1'b1, base + eth_pkg::OFF_TC, tc[i]);
			die_temp <= 16'(dt[i]);
			meas();
			rise = step(rise, th[i], tu[i], 128);
			apb(1'b0, base + eth_pkg::OFF_RISE, 32'h0);
			chk("rise", rd, rise);
			ex = corr(tc[i], dt[i] + rise - 6400);
			chk("corr", gain_corr[ch*16 +: 16], ex);
		end
		apb(1'b0, 8'((ch ^ 1) * 32) + eth_pkg::OFF_RISE, 32'h0);
		chk("other rise", rd, 32'h0);
		$display("test self heating done");
		summarize();
	end
endmodule
bind eth_model eth_model_monitor chk_u (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.meas_done(meas_done), .temp_out(temp_out), .gain_corr(gain_corr));

// ===== rtl/eth_model.sv
// Four-channel calibrated temperature and inductor self-heating model.
// Assumes an APB master on pclk; sense inputs are synchronous to pclk
// and meas_done marks the end of one full external-temperature loop.
//
// Function
// R1: Temperature = kelvin reading times gain minus 273.15 plus offset.
// R2: Gain code is unsigned, LSB two to minus fourteen, 0x4000 is unity.
// R3: Invalid sensor uses die temperature; gain and offset are ignored.
// R4: Invalid sensor makes die temperature the model reference.
// R5: Sensor temperature plus modelled rise drives sense-gain correction.
// R6: Rise starts at zero; each measurement adds the signed increment.
// R7: Increment is tau_inv times (power times theta minus rise).
// R8: Power is sense current times differential sense voltage.
// R9: Model step is four conversion times, one full temperature loop.
// R10: Rise is clamped to 0 to 50 degrees inclusive.
// R11: Theta or tau_inv at or below zero forces the rise to zero.
// R12: Tau_inv at or above one sets rise to theta times power.
// R13: Correction is 1 + tc*1e-6*(T+rise-25), clamped 0.25 to 4.0.
// R14: Tempco is a signed 16-bit integer in ppm per degree.
// R15: Each channel keeps its own settings, rise and sense inputs.
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
module eth_model (
	// Clock and reset
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	// APB slave
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [7:0]                     paddr,
	input  wire logic [31:0]                    pwdata,
	input  wire logic [3:0]                     pstrb,
	output logic      [31:0]                    prdata,
	output logic                                pready,
	output logic                                pslverr,
	// Measurements, one lane per channel except shared meas_done and die_temp
	input  wire logic                           meas_done,
	input  wire logic [eth_pkg::NCH-1:0]        sensor_valid,
	input  wire logic [eth_pkg::NCH*16-1:0]     diode_kelvin,
	input  wire logic [15:0]                    die_temp,
	input  wire logic [eth_pkg::NCH*16-1:0]     sense_current,
	input  wire logic [eth_pkg::NCH*16-1:0]     sense_plus_voltage,
	input  wire logic [eth_pkg::NCH*16-1:0]     sense_minus_voltage,
	// Results
	output logic      [eth_pkg::NCH*16-1:0]     temp_out,
	output logic      [eth_pkg::NCH*16-1:0]     gain_corr
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Saturate a signed value into a signed range
	function automatic logic signed [47:0] clamp48(
		input logic signed [47:0] v,
		input logic signed [47:0] lo,
		input logic signed [47:0] hi);
		clamp48 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// ------------------------------------------------------------
	// Register storage, one set per channel
	// ------------------------------------------------------------
	logic [15:0] gain_q   [eth_pkg::NCH];
	logic [15:0] offset_q [eth_pkg::NCH];
	logic [15:0] theta_q  [eth_pkg::NCH];
	logic [15:0] tau_q    [eth_pkg::NCH];
	logic [15:0] tc_q     [eth_pkg::NCH];
	logic [15:0] rise_q   [eth_pkg::NCH];
	logic [15:0] temp_q   [eth_pkg::NCH];
	logic [15:0] corr_q   [eth_pkg::NCH];

	// APB decode
	wire        acc_w   = psel & penable;
	wire        wr_w    = acc_w & pwrite & pstrb[0] & pstrb[1];
	wire [1:0]  ch_w    = paddr[6:5];
	wire [4:0]  reg_w   = paddr[4:0];
	wire        hi_w    = paddr[7];
	wire        is_ro_w = (reg_w == eth_pkg::OFF_RISE) ||
		(reg_w == eth_pkg::OFF_TEMP) || (reg_w == eth_pkg::OFF_CORR);
	wire        bad_w   = hi_w || (reg_w[1:0] != 2'h0);
	logic [15:0] rd_mux;

	// Read data selection
	always_comb begin
		unique case (reg_w)
			eth_pkg::OFF_GAIN:   rd_mux = gain_q[ch_w];
			eth_pkg::OFF_OFFSET: rd_mux = offset_q[ch_w];
			eth_pkg::OFF_THETA:  rd_mux = theta_q[ch_w];
			eth_pkg::OFF_TAU:    rd_mux = tau_q[ch_w];
			eth_pkg::OFF_TC:     rd_mux = tc_q[ch_w];
			eth_pkg::OFF_RISE:   rd_mux = rise_q[ch_w];
			eth_pkg::OFF_TEMP:   rd_mux = temp_q[ch_w];
			eth_pkg::OFF_CORR:   rd_mux = corr_q[ch_w];
			default:             rd_mux = 16'h0000;
		endcase
	end

	// ------------------------------------------------------------
	// APB response: one wait state, error on unmapped or RO write
	// ------------------------------------------------------------
	logic pready_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			prdata   <= 32'h0000_0000;
			pslverr  <= 1'b0;
		end else begin
			pready_q <= acc_w & ~pready_q;
			pslverr  <= acc_w & ~pready_q & (bad_w | (pwrite & is_ro_w));
			prdata   <= (acc_w & ~pready_q & ~pwrite & ~bad_w) ?
				{16'h0000, rd_mux} : 32'h0000_0000;
		end
	end
	assign pready = pready_q;

	// Settings written by software, per channel
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < eth_pkg::NCH; i++) begin
				gain_q[i]   <= eth_pkg::GAIN_RST;   // R2
				offset_q[i] <= eth_pkg::OFFSET_RST;
				theta_q[i]  <= eth_pkg::THETA_RST;
				tau_q[i]    <= eth_pkg::TAU_RST;
				tc_q[i]     <= eth_pkg::TC_RST;
			end
		end else if (wr_w & pready_q & ~bad_w) begin
			unique case (reg_w)
				eth_pkg::OFF_GAIN:   gain_q[ch_w]   <= pwdata[15:0];
				eth_pkg::OFF_OFFSET: offset_q[ch_w] <= pwdata[15:0];
				eth_pkg::OFF_THETA:  theta_q[ch_w]  <= pwdata[15:0];
				eth_pkg::OFF_TAU:    tau_q[ch_w]    <= pwdata[15:0];
				eth_pkg::OFF_TC:     tc_q[ch_w]     <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Per-channel arithmetic (combinational, from stored state and live sensor inputs)
	// ------------------------------------------------------------
	logic [15:0] temp_d [eth_pkg::NCH];
	logic [15:0] rise_d [eth_pkg::NCH];
	logic [15:0] corr_d [eth_pkg::NCH];

	always_comb begin
		for (int c = 0; c < eth_pkg::NCH; c++) begin
			logic        [31:0] kxg;
			logic signed [31:0] tcal;
			logic signed [31:0] ts;
			logic signed [31:0] vdiff;
			logic signed [31:0] pwr;
			logic signed [47:0] ss;
			logic signed [47:0] inc;
			logic signed [47:0] rnew;
			logic signed [47:0] tsum;
			logic signed [47:0] corr;
			// Every local starts from zero on each pass
			kxg   = '0;
			tcal  = '0;
			ts    = '0;
			vdiff = '0;
			pwr   = '0;
			ss    = '0;
			inc   = '0;
			rnew  = '0;
			tsum  = '0;
			corr  = '0;
			// Kelvin Q10.6 * gain Q2.14 -> Q8.8 after shift
			kxg  = (32'(diode_kelvin[c*16 +: 16]) *
				32'(gain_q[c])) >> (eth_pkg::GAIN_FRAC - 2);  // R1 R2
			tcal = $signed(kxg - eth_pkg::KELVIN_OFS) +
				32'(signed'(offset_q[c]));                     // R1
			// Die temperature takes over when the sensor is bad
			ts   = sensor_valid[c] ? tcal :
				32'(signed'(die_temp));                        // R3 R4 R15
			// Dissipated power in the sense element
			vdiff = 32'(signed'(sense_plus_voltage[c*16 +: 16])) -
				32'(signed'(sense_minus_voltage[c*16 +: 16]));  // R8
			pwr  = (32'(signed'(sense_current[c*16 +: 16])) * vdiff)
				>>> eth_pkg::P_SHIFT;                          // R8
			ss   = (48'(pwr) * 48'(signed'(theta_q[c]))) >>> 8;
			inc  = ((ss - 48'(signed'(rise_q[c]))) *
				48'(signed'(tau_q[c]))) >>> eth_pkg::TAU_FRAC; // R7
			if ($signed(theta_q[c]) <= 0 || $signed(tau_q[c]) <= 0)
				rnew = 48'sd0;                                 // R11
			else if ($signed(tau_q[c]) >= (1 <<< eth_pkg::TAU_FRAC) - 1)
				rnew = ss;                                     // R12
			else
				rnew = 48'(signed'(rise_q[c])) + inc;          // R6
			rnew = clamp48(rnew, 48'sd0,
				48'(eth_pkg::RISE_MAX));                       // R10
			// Correction uses sensor temperature plus new rise
			tsum = 48'(ts) + rnew - 48'(eth_pkg::T_REF);       // R5
			corr = (1 <<< eth_pkg::CORR_FRAC) +
				((48'(signed'(tc_q[c])) * tsum *
				(1 <<< eth_pkg::CORR_FRAC)) /
				(eth_pkg::PPM_DIV <<< 8));                     // R13 R14
			corr = clamp48(corr, eth_pkg::CORR_MIN,
				eth_pkg::CORR_MAX);                            // R13
			temp_d[c] = ts[15:0];
			rise_d[c] = rnew[15:0];
			corr_d[c] = (corr == eth_pkg::CORR_MAX) ? 16'hffff :
				corr[15:0];
		end
	end

	// ------------------------------------------------------------
	// Model update, once per complete temperature loop
	// ------------------------------------------------------------
	logic [31:0] step_cnt_q;
	wire         step_w = meas_done;          // R9

	// Loop period monitor, counts cycles between steps; no register reads it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			step_cnt_q <= 32'h0000_0000;
		else
			step_cnt_q <= step_w ? 32'h0000_0000 : step_cnt_q + 32'h1;
	end

	// State update on each loop completion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < eth_pkg::NCH; i++) begin
				rise_q[i] <= 16'h0000;                         // R6
				temp_q[i] <= 16'h0000;
				corr_q[i] <= 16'h4000;
			end
		end else if (step_w) begin
			for (int i = 0; i < eth_pkg::NCH; i++) begin
				rise_q[i] <= rise_d[i];                        // R6 R15
				temp_q[i] <= temp_d[i];
				corr_q[i] <= corr_d[i];                        // R5
			end
		end
	end

	// Flatten results onto the output buses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			temp_out  <= '0;
			gain_corr <= '0;
		end else begin
			for (int i = 0; i < eth_pkg::NCH; i++) begin
				temp_out[i*16 +: 16]  <= temp_q[i];
				gain_corr[i*16 +: 16] <= corr_q[i];
			end
		end
	end

endmodule
